// >>> rtl/modem_pkg.sv
package modem_pkg;
  localparam int NUM_CH = 2;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam int MSR_DCD_BIT = 7;
  localparam int MSR_DSR_BIT = 5;
  localparam int MSR_DDCD_BIT = 3;
  localparam int MSR_DDSR_BIT = 1;
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_LOOP_BIT = 4;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [1:0] PIN_RESET = 2'h3;

  typedef struct packed {
    logic [2:0] addr;
    logic [DATA_W-1:0] wdata;
    logic cs_b;
    logic rd_b;
    logic wr_b;
  } cpu_req_s;

  typedef struct packed {
    logic dcd_b;
    logic dsr_b;
  } modem_pins_s;
endpackage

// >>> rtl/modem_channel.sv
`timescale 1ns/1ps
module modem_channel
  import modem_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire modem_pins_s pins_i,
  input wire logic [2:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic msi_en_i,
  output logic [DATA_W-1:0] msr_o,
  output logic irq_o,
  output logic dtr_b_o
);
  logic [1:0] sync1, sync2, last;
  logic dcd_chg, dsr_chg;
  logic [DATA_W-1:0] modem_control_reg;
  logic [1:0] next_sync1, next_sync2, next_last;
  logic next_dcd_chg, next_dsr_chg;
  logic [DATA_W-1:0] next_mcr;
  logic rd_msr;
  logic [1:0] edge_seen;

  always_comb begin
    rd_msr = rd_i && (addr_i == REG_MSR);
    next_sync1 = {pins_i.dcd_b, pins_i.dsr_b};
    next_sync2 = sync1;
    next_last = sync2;
    edge_seen = sync2 ^ last;
    // Set beats the read clear so an edge during the read is not lost
    next_dcd_chg = edge_seen[1] | (dcd_chg & ~rd_msr);
    next_dsr_chg = edge_seen[0] | (dsr_chg & ~rd_msr);
    next_mcr = modem_control_reg;
    if (wr_i && addr_i == REG_MCR) begin
      next_mcr = wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= PIN_RESET;
      sync2 <= PIN_RESET;
      last <= PIN_RESET;
      dcd_chg <= 1'b0;
      dsr_chg <= 1'b0;
      modem_control_reg <= MCR_RESET;
    end else if (ce_i) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      last <= next_last;
      dcd_chg <= next_dcd_chg;
      dsr_chg <= next_dsr_chg;
      modem_control_reg <= next_mcr;
    end
  end

  always_comb begin
    msr_o = '0;
    msr_o[MSR_DCD_BIT] = ~last[1];
    msr_o[MSR_DSR_BIT] = ~last[0];
    msr_o[MSR_DDCD_BIT] = dcd_chg;
    msr_o[MSR_DDSR_BIT] = dsr_chg;
  end

  assign irq_o = msi_en_i & (dcd_chg | dsr_chg);
  // Loopback forces the pin inactive; reset clears the control bit
  assign dtr_b_o = ~(modem_control_reg[MCR_DTR_BIT] & ~modem_control_reg[MCR_LOOP_BIT]);

  AST_DCD_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && edge_seen[1] |=> dcd_chg) else $error("carrier change not flagged");
  AST_DSR_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && edge_seen[0] |=> dsr_chg) else $error("dsr change not flagged");
  AST_READ_CLR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && rd_msr && edge_seen == 2'h0 |=> !dcd_chg && !dsr_chg)
    else $error("read did not clear flags");
  AST_DCD_IRQ: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && msi_en_i && edge_seen[1] ##1 msi_en_i |-> irq_o) else $error("no carrier irq");
  AST_DSR_IRQ: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && edge_seen[0] ##1 msi_en_i |-> irq_o) else $error("no dsr irq");
  AST_IRQ_CAUSE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    irq_o |-> msi_en_i && (msr_o[MSR_DDCD_BIT] || msr_o[MSR_DDSR_BIT])) else $error("spurious irq");
  AST_DCD_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i |=> msr_o[MSR_DCD_BIT] == !$past(sync2[1])) else $error("carrier level wrong");
  AST_DSR_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i |=> msr_o[MSR_DSR_BIT] == !$past(sync2[0])) else $error("dsr level wrong");
  AST_DTR_ON: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == REG_MCR && wdata_i[MCR_DTR_BIT] && !wdata_i[MCR_LOOP_BIT] |=> !dtr_b_o)
    else $error("dtr not driven active");
  AST_DTR_OFF: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    modem_control_reg[MCR_LOOP_BIT] || !modem_control_reg[MCR_DTR_BIT] |-> dtr_b_o) else $error("dtr active when it must not be");
endmodule // modem_channel

// >>> rtl/modem_handshake.sv
`timescale 1ns/1ps
module modem_handshake
  import modem_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire cpu_req_s [NUM_CH-1:0] cpu_req_i,
  input wire logic [DATA_W-1:0] cpu_data_bus_i,
  input wire modem_pins_s [NUM_CH-1:0] pins_i,
  input wire logic [NUM_CH-1:0] msi_en_i,
  output logic [DATA_W-1:0] cpu_data_bus_o,
  output logic cpu_data_bus_oe_o,
  output logic channel0_irq_o,
  output logic channel1_irq_o,
  output logic [NUM_CH-1:0] dtr_b_o
);
  logic [NUM_CH-1:0] rd, wr;
  logic [DATA_W-1:0] modem_status_reg [NUM_CH];
  logic [NUM_CH-1:0] irq;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rd_any;

  // CPU strobes are treated as synchronous to clock_i
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign rd[g] = !cpu_req_i[g].cs_b && !cpu_req_i[g].rd_b;
      assign wr[g] = !cpu_req_i[g].cs_b && !cpu_req_i[g].wr_b;
      modem_channel u_ch (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .pins_i(pins_i[g]),
        .addr_i(cpu_req_i[g].addr),
        .wdata_i(cpu_data_bus_i),
        .rd_i(rd[g]),
        .wr_i(wr[g]),
        .msi_en_i(msi_en_i[g]),
        .msr_o(modem_status_reg[g]),
        .irq_o(irq[g]),
        .dtr_b_o(dtr_b_o[g])
      );
    end
  endgenerate

  always_comb begin
    next_rdata = rdata;
    if (rd[0] && cpu_req_i[0].addr == REG_MSR) begin
      next_rdata = modem_status_reg[0];
    end else if (rd[1] && cpu_req_i[1].addr == REG_MSR) begin
      next_rdata = modem_status_reg[1];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata <= '0;
    end else if (ce_i) begin
      rdata <= next_rdata;
    end
  end

  assign rd_any = |rd;
  assign cpu_data_bus_o = rdata;
  assign cpu_data_bus_oe_o = rd_any;
  assign channel0_irq_o = irq[0];
  assign channel1_irq_o = irq[1];

  // Bus enable must follow the read strobes of both channels, not just one
  AST_BUS_OE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cpu_data_bus_oe_o == (!cpu_req_i[0].cs_b && !cpu_req_i[0].rd_b || !cpu_req_i[1].cs_b && !cpu_req_i[1].rd_b))
    else $error("bus enable does not follow read strobe");
  AST_RD0_DATA: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && rd[0] && cpu_req_i[0].addr == REG_MSR |=> cpu_data_bus_o == $past(modem_status_reg[0]))
    else $error("channel 0 status not returned");
  AST_RD1_DATA: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && rd[1] && !rd[0] && cpu_req_i[1].addr == REG_MSR |=> cpu_data_bus_o == $past(modem_status_reg[1]))
    else $error("channel 1 status not returned");
  AST_RD_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !(rd[0] && cpu_req_i[0].addr == REG_MSR) && !(rd[1] && cpu_req_i[1].addr == REG_MSR)
    |=> cpu_data_bus_o == $past(cpu_data_bus_o)) else $error("read data changed without status read");
  AST_IRQ0_MAP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    channel0_irq_o == (msi_en_i[0] && (modem_status_reg[0][MSR_DDCD_BIT] || modem_status_reg[0][MSR_DDSR_BIT])))
    else $error("channel 0 interrupt wrong");
  AST_IRQ1_MAP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    channel1_irq_o == (msi_en_i[1] && (modem_status_reg[1][MSR_DDCD_BIT] || modem_status_reg[1][MSR_DDSR_BIT])))
    else $error("channel 1 interrupt wrong");
endmodule // modem_handshake

// >>> test/modem_model.sv
`timescale 1ns/1ps
module modem_model
  import modem_pkg::*;
(
  input wire logic [NUM_CH-1:0] dcd_on_i,
  input wire logic [NUM_CH-1:0] dsr_on_i,
  output modem_pins_s [NUM_CH-1:0] pins_o
);
  // Handshake pins are active low, so an asserted line reads as 0
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pins_o[c].dcd_b = ~dcd_on_i[c];
      pins_o[c].dsr_b = ~dsr_on_i[c];
    end
  end
endmodule // modem_model

// >>> test/test_modem_handshake.sv
`timescale 1ns/1ps
module test_modem_handshake
  import modem_pkg::*;
;
  logic clock_i = 1'h0;
  logic rst_b_i = 1'h0;
  cpu_req_s [NUM_CH-1:0] req = '1;
  logic [DATA_W-1:0] wd = 8'h00;
  logic [NUM_CH-1:0] msi = 2'h3;
  logic [NUM_CH-1:0] dcd = 2'h0;
  logic [NUM_CH-1:0] dsr = 2'h0;
  modem_pins_s [NUM_CH-1:0] pins;
  logic [DATA_W-1:0] rdata;
  logic oe, irq0, irq1;
  logic [NUM_CH-1:0] dtr_b;
  int n_mismatch = 0;
  int compares = 0;

  initial forever #50 clock_i = ~clock_i;

  modem_model i_model (.dcd_on_i(dcd), .dsr_on_i(dsr), .pins_o(pins));
  modem_handshake i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(1'h1), .cpu_req_i(req),
    .cpu_data_bus_i(wd), .pins_i(pins), .msi_en_i(msi), .cpu_data_bus_o(rdata),
    .cpu_data_bus_oe_o(oe), .channel0_irq_o(irq0), .channel1_irq_o(irq1), .dtr_b_o(dtr_b));

  task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Strobe held from a falling edge through the taking rising edge
  task acc(input int ch, input logic [2:0] a, input logic wr, input logic [DATA_W-1:0] d);
    @(negedge clock_i);
    req[ch].addr = a;
    req[ch].cs_b = 1'h0;
    req[ch].rd_b = wr;
    req[ch].wr_b = ~wr;
    wd = d;
    @(posedge clock_i);
    #1 if (!wr) chk(oe, 8'h01);
    @(negedge clock_i);
    req = '1;
    @(negedge clock_i);
  endtask

  task close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Sequence needs well under 200 cycles
  initial begin
    #500000;
    n_mismatch++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    rst_b_i = 1'h1;
    chk(dtr_b, 8'h03);
    acc(0, REG_MCR, 1'h1, 8'h01); chk(dtr_b, 8'h02);
    acc(0, REG_MCR, 1'h1, 8'h11); chk(dtr_b, 8'h03);
    acc(0, REG_MCR, 1'h1, 8'h01); chk(dtr_b, 8'h02);
    acc(0, REG_MCR, 1'h1, 8'h00); chk(dtr_b, 8'h03);
    // Pins pass a two-flop sync, so allow a few cycles before looking
    dcd = 2'h1;
    repeat (6) @(negedge clock_i);
    chk({irq1, irq0}, 8'h01);
    acc(0, REG_MSR, 1'h0, 8'h00); chk(rdata, 8'h88);
    chk(irq0, 8'h00);
    // Unmapped read leaves the last data in place
    acc(0, 3'h0, 1'h0, 8'h00); chk(rdata, 8'h88);
    acc(0, REG_MSR, 1'h0, 8'h00); chk(rdata, 8'h80);
    msi = 2'h2;
    dsr = 2'h3;
    repeat (6) @(negedge clock_i);
    chk({irq1, irq0}, 8'h02);
    acc(1, REG_MSR, 1'h0, 8'h00); chk(rdata, 8'h22);
    acc(0, REG_MSR, 1'h0, 8'h00); chk(rdata, 8'hA2);
    chk({irq1, irq0}, 8'h00);
    close_out;
  end
endmodule // test_modem_handshake
